// ---- flash_guard_pkg.sv ----
package flash_guard_pkg;
  // Key sequence
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  // Lock state codes read back from the key register
  localparam logic [1:0] KEY_CODE_LOCKED = 2'h0;
  localparam logic [1:0] KEY_CODE_FIRST = 2'h1;
  localparam logic [1:0] KEY_CODE_UNLOCKED = 2'h2;
  localparam logic [1:0] KEY_CODE_DISABLED = 2'h3;
  // Special function register addresses
  localparam logic [7:0] STORE_CTRL_ADDR = 8'h8F;
  localparam logic [7:0] KEY_LOCK_ADDR = 8'hB7;
  localparam logic [7:0] RST_CAUSE_ADDR = 8'hEF;
  localparam int WRITE_EN_BIT = 0;
  localparam int ERASE_EN_BIT = 1;
  localparam logic [7:0] STORE_CTRL_RESET = 8'h00;
  localparam logic [7:0] KEY_LOCK_RESET = 8'h00;
  localparam int FLASH_ERR_BIT = 6;
  // Flash geometry
  localparam int FLASH_BYTES = 8192;
  localparam int ADDR_W = 13;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_W = 9;
  localparam logic [12:0] LOCK_ADDR = 13'h1DFF;
  localparam logic [3:0] LOCK_PAGE = 4'hE;
  localparam logic [12:0] RSV_BASE = 13'h1E00;
  localparam logic [7:0] ERASED = 8'hFF;
  // Operation timing
  localparam int CLK_NS = 4;
  localparam int WRITE_NS = 40;
  localparam int ERASE_NS = 400;
  localparam int WRITE_CYC = (WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 7;
  // Controller register map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ADDR_OFF = 8'h04;
  localparam logic [7:0] WDATA_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam logic [7:0] INT_STAT_OFF = 8'h10;
  localparam logic [7:0] INT_CLR_OFF = 8'h14;
  localparam logic [7:0] INT_EN_OFF = 8'h18;
  localparam int STATUS_BUSY_BIT = 8;
  localparam int INT_CMD_DONE = 0;
  localparam int INT_REFUSED = 1;
  localparam int INT_FERR = 2;
  localparam int INT_OP_DONE = 3;
  localparam int INT_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    rq_sfr_wr, rq_sfr_rd, rq_xmove_wr, rq_code_rd,
    rq_dbg_rd, rq_dbg_wr, rq_dbg_page_erase, rq_dbg_dev_erase
  } req_kind_e;
endpackage : flash_guard_pkg

// ---- flash_guard_if.sv ----
`timescale 1ns/1ns
interface flash_guard_if;
  import flash_guard_pkg::*;
  logic req;
  req_kind_e kind;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic busy;
  logic cmd_done;
  logic [7:0] rdata;
  logic refused;
  logic op_done;
  logic err_reset;

  modport device (
    input req, kind, addr, wdata,
    output busy, cmd_done, rdata, refused, op_done, err_reset
  );
  modport host (
    output req, kind, addr, wdata,
    input busy, cmd_done, rdata, refused, op_done, err_reset
  );
endinterface : flash_guard_if

// ---- flash_guard_device.sv ----
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module flash_guard_device (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core and debug requests
  flash_guard_if.device link,
  // Chip reset request and its cause
  output logic dev_reset,
  output logic ferr_flag
);
  import flash_guard_pkg::*;

  typedef enum logic [1:0] {key_locked, key_first, key_unlocked, key_disabled} key_state_e;
  typedef enum logic [1:0] {op_write, op_erase_page, op_erase_all} op_e;

  logic [7:0] mem_r [FLASH_BYTES];
  key_state_e key_r;
  logic [1:0] store_ctrl_r;
  logic [7:0] lock_img_r;
  logic busy_r;
  logic op_user_r;
  op_e op_sel_r;
  logic [ADDR_W-1:0] op_addr_r;
  logic [7:0] op_data_r;
  logic [CNT_W-1:0] cnt_r;
  logic ferr_rst_r;
  logic ferr_flag_r;
  logic cmd_done_r;
  logic refused_r;
  logic op_done_r;
  logic [7:0] rdata_r;

  logic [ADDR_W-1:0] a;
  logic a_rsv;
  logic a_lock;
  logic any_locked;
  logic page_locked;
  logic lock_written;
  logic req_go;
  logic is_dbg;
  logic user_flash_wr;
  logic user_forbid;
  logic dbg_forbid;
  logic key_misuse;
  logic ferr_hit;
  logic dbg_refuse;
  logic start_user;
  logic start_dbg;
  op_e start_sel;
  logic op_end;
  logic dev_rst;
  logic [1:0] key_code;

  assign op_end = busy_r && (cnt_r == '0);
  assign dev_rst = !aresetn || ferr_rst_r;

  always_comb begin
    a = link.addr[ADDR_W-1:0];
    a_rsv = (link.addr[15:ADDR_W] != '0) || (a >= RSV_BASE);
    a_lock = (a == LOCK_ADDR);
    any_locked = (lock_img_r != ERASED);
    // Each lock byte bit guards a pair of pages
    page_locked = !lock_img_r[a[ADDR_W-1 -: 3]]
                  || ((a[ADDR_W-1:PAGE_W] == LOCK_PAGE) && any_locked);
    lock_written = (mem_r[LOCK_ADDR] != ERASED);
    req_go = link.req && !busy_r;
    is_dbg = link.kind inside {rq_dbg_rd, rq_dbg_wr, rq_dbg_page_erase, rq_dbg_dev_erase};
    user_flash_wr = req_go && (link.kind == rq_xmove_wr) && store_ctrl_r[WRITE_EN_BIT];
    // Programming a written lock byte, lock page erase while locked
    user_forbid = a_rsv || page_locked
                  || (a_lock && lock_written && !store_ctrl_r[ERASE_EN_BIT]);
    unique case (link.kind)
      rq_dbg_rd: dbg_forbid = a_rsv || page_locked;
      rq_dbg_wr: dbg_forbid = a_rsv || page_locked || (a_lock && lock_written);
      rq_dbg_page_erase: dbg_forbid = a_rsv || page_locked;
      default: dbg_forbid = 1'b0;
    endcase
    key_misuse = user_flash_wr && (key_r != key_unlocked);
    ferr_hit = (user_flash_wr && (key_r == key_unlocked) && user_forbid)
               || (req_go && (link.kind == rq_code_rd) && a_rsv);
    dbg_refuse = req_go && is_dbg && dbg_forbid;
    start_user = user_flash_wr && (key_r == key_unlocked) && !user_forbid;
    start_dbg = req_go && !dbg_forbid
                && (link.kind inside {rq_dbg_wr, rq_dbg_page_erase, rq_dbg_dev_erase});
    if (start_user) begin
      start_sel = store_ctrl_r[ERASE_EN_BIT] ? op_erase_page : op_write;
    end else if (link.kind == rq_dbg_dev_erase) begin
      start_sel = op_erase_all;
    end else if (link.kind == rq_dbg_page_erase) begin
      start_sel = op_erase_page;
    end else begin
      start_sel = op_write;
    end
    unique case (key_r)
      key_locked: key_code = KEY_CODE_LOCKED;
      key_first: key_code = KEY_CODE_FIRST;
      key_unlocked: key_code = KEY_CODE_UNLOCKED;
      key_disabled: key_code = KEY_CODE_DISABLED;
    endcase
  end

  // Flash array; only power-on clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < FLASH_BYTES; i++) begin
        mem_r[i] <= ERASED;
      end
    end else if (op_end) begin
      unique case (op_sel_r)
        // Programming only clears bits, so new data is ANDed into unerased bytes
        op_write: mem_r[op_addr_r] <= mem_r[op_addr_r] & op_data_r;
        op_erase_page: begin
          for (int i = 0; i < FLASH_BYTES; i++) begin
            if (i / PAGE_BYTES == int'(op_addr_r[ADDR_W-1:PAGE_W])) begin
              mem_r[i] <= ERASED;
            end
          end
        end
        op_erase_all: begin
          for (int i = 0; i < FLASH_BYTES; i++) begin
            mem_r[i] <= ERASED;
          end
        end
      endcase
    end
  end

  // Key sequencer
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      key_r <= key_locked;
    end else if (op_end && op_user_r) begin
      key_r <= (key_r == key_disabled) ? key_disabled : key_locked;
    end else if (key_misuse) begin
      key_r <= key_disabled;
    end else if (req_go && (link.kind == rq_sfr_wr) && (link.addr[7:0] == KEY_LOCK_ADDR)) begin
      unique case (key_r)
        key_locked: key_r <= (link.wdata == KEY_FIRST) ? key_first : key_disabled;
        key_first: key_r <= (link.wdata == KEY_SECOND) ? key_unlocked : key_disabled;
        key_unlocked: key_r <= key_disabled;
        key_disabled: key_r <= key_disabled;
      endcase
    end
  end

  // Reserved control bits are never stored
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      store_ctrl_r <= STORE_CTRL_RESET[1:0];
    end else if (req_go && (link.kind == rq_sfr_wr) && (link.addr[7:0] == STORE_CTRL_ADDR)) begin
      store_ctrl_r <= {link.wdata[ERASE_EN_BIT], link.wdata[WRITE_EN_BIT]};
    end
  end

  // Protection image is sampled from flash only at an error reset; power-on and a device erase set it erased
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_img_r <= ERASED;
    end else if (ferr_rst_r) begin
      lock_img_r <= mem_r[LOCK_ADDR];
    end else if (op_end && (op_sel_r == op_erase_all)) begin
      lock_img_r <= ERASED;
    end
  end

  // Operation engine; requests are only taken while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      op_user_r <= 1'b0;
      op_sel_r <= op_write;
      op_addr_r <= '0;
      op_data_r <= 8'h00;
      cnt_r <= '0;
    end else if (start_user || start_dbg) begin
      busy_r <= 1'b1;
      op_user_r <= start_user;
      op_sel_r <= start_sel;
      op_addr_r <= a;
      op_data_r <= link.wdata;
      cnt_r <= (start_sel == op_write) ? CNT_W'(WRITE_CYC - 1) : CNT_W'(ERASE_CYC - 1);
    end else if (op_end) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // Error reset pulse and its sticky cause flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ferr_rst_r <= 1'b0;
      ferr_flag_r <= 1'b0;
    end else begin
      ferr_rst_r <= ferr_hit;
      if (ferr_rst_r) begin
        ferr_flag_r <= 1'b1;
      end
    end
  end

  // Answers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_done_r <= 1'b0;
      refused_r <= 1'b0;
      op_done_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      cmd_done_r <= req_go;
      refused_r <= dbg_refuse;
      op_done_r <= op_end;
      if (req_go) begin
        unique case (link.kind)
          rq_sfr_rd: begin
            if (link.addr[7:0] == STORE_CTRL_ADDR) begin
              rdata_r <= {6'h00, store_ctrl_r};
            end else if (link.addr[7:0] == KEY_LOCK_ADDR) begin
              rdata_r <= {6'h00, key_code};
            end else if (link.addr[7:0] == RST_CAUSE_ADDR) begin
              rdata_r <= 8'(ferr_flag_r) << FLASH_ERR_BIT;
            end else begin
              rdata_r <= 8'h00;
            end
          end
          rq_code_rd: rdata_r <= a_rsv ? 8'h00 : mem_r[a];
          rq_dbg_rd: rdata_r <= dbg_forbid ? 8'h00 : mem_r[a];
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign link.busy = busy_r;
  assign link.cmd_done = cmd_done_r;
  assign link.rdata = rdata_r;
  assign link.refused = refused_r;
  assign link.op_done = op_done_r;
  assign link.err_reset = ferr_rst_r;
  assign dev_reset = ferr_rst_r;
  assign ferr_flag = ferr_flag_r;
endmodule : flash_guard_device

// ---- flash_guard_host.sv ----
`timescale 1ns/1ns
module flash_guard_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device link
  flash_guard_if.host link,
  // Interrupt
  output logic irq
);
  import flash_guard_pkg::*;

  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic pend_r, wait_r, req_r;
  req_kind_e kind_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] cap_r;
  logic [INT_W-1:0] int_stat_r, int_en_r;
  logic take_aw, take_w, take_ar, wr_fire, known_wr, known_rd;
  logic [31:0] mask;
  logic [INT_W-1:0] ev, clr;

  always_comb begin
    take_aw = s_axi_awvalid && awready_r;
    take_w = s_axi_wvalid && wready_r;
    take_ar = s_axi_arvalid && arready_r;
    wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    known_wr = aw_addr_r inside {CTRL_OFF, ADDR_OFF, WDATA_OFF, INT_CLR_OFF, INT_EN_OFF};
    known_rd = s_axi_araddr inside {CTRL_OFF, ADDR_OFF, WDATA_OFF, STATUS_OFF, INT_STAT_OFF,
                                    INT_EN_OFF};
    clr = (wr_fire && aw_addr_r == INT_CLR_OFF) ? INT_W'(w_data_r & mask) : '0;
    ev = '0;
    ev[INT_CMD_DONE] = wait_r && link.cmd_done;
    ev[INT_REFUSED] = link.refused;
    ev[INT_FERR] = link.err_reset;
    ev[INT_OP_DONE] = link.op_done;
  end

  // Write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (take_aw) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (take_w) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
      awready_r <= !(aw_hold_r || take_aw || bvalid_r);
      wready_r <= !(w_hold_r || take_w || bvalid_r);
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= known_wr ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= !(take_ar || rvalid_r);
      if (take_ar) begin
        rvalid_r <= 1'b1;
        rresp_r <= known_rd ? RESP_OKAY : RESP_SLVERR;
        unique case (s_axi_araddr)
          CTRL_OFF: rdata_r <= 32'(kind_r);
          ADDR_OFF: rdata_r <= 32'(addr_r);
          WDATA_OFF: rdata_r <= 32'(wdata_r);
          STATUS_OFF: rdata_r <= 32'(cap_r) | (32'(pend_r || wait_r) << STATUS_BUSY_BIT);
          INT_STAT_OFF: rdata_r <= 32'(int_stat_r);
          INT_EN_OFF: rdata_r <= 32'(int_en_r);
          default: rdata_r <= 32'h00000000;
        endcase
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Command registers; a command written while busy is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_r <= rq_sfr_rd;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      int_en_r <= '0;
    end else if (wr_fire) begin
      unique case (aw_addr_r)
        CTRL_OFF: begin
          if (!pend_r && !wait_r && w_strb_r[0]) begin
            kind_r <= req_kind_e'(w_data_r[2:0]);
          end
        end
        ADDR_OFF: addr_r <= 16'((32'(addr_r) & ~mask) | (w_data_r & mask));
        WDATA_OFF: wdata_r <= w_strb_r[0] ? w_data_r[7:0] : wdata_r;
        INT_EN_OFF: int_en_r <= INT_W'((32'(int_en_r) & ~mask) | (w_data_r & mask));
        default: ;
      endcase
    end
  end

  // Request issue: one outstanding, waits for the device's answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= 1'b0;
      wait_r <= 1'b0;
      req_r <= 1'b0;
      cap_r <= 8'h00;
    end else begin
      req_r <= 1'b0;
      if (wr_fire && aw_addr_r == CTRL_OFF && !pend_r && !wait_r && w_strb_r[0]) begin
        pend_r <= 1'b1;
      end else if (pend_r && !wait_r && !link.busy) begin
        pend_r <= 1'b0;
        wait_r <= 1'b1;
        req_r <= 1'b1;
      end else if (wait_r && link.cmd_done) begin
        wait_r <= 1'b0;
        cap_r <= link.rdata;
      end
    end
  end

  // Sticky status; a new event wins over its clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r & ~clr) | ev;
      irq_r <= |(int_stat_r & int_en_r);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign link.req = req_r;
  assign link.kind = kind_r;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;
  assign irq = irq_r;
endmodule : flash_guard_host

// ---- flash_guard_properties.sv ----
`timescale 1ns/1ns
module flash_guard_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests
  input wire logic req,
  input flash_guard_pkg::req_kind_e kind,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  // Answers
  input wire logic busy,
  input wire logic cmd_done,
  input wire logic [7:0] rdata,
  input wire logic refused,
  input wire logic op_done,
  input wire logic err_reset
);
  import flash_guard_pkg::*;
  logic [7:0] busy_len_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Length of the last busy stretch, held after it ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_len_r <= 8'h00;
    end else if (req && !busy) begin
      busy_len_r <= 8'h00;
    end else if (busy) begin
      busy_len_r <= busy_len_r + 8'h01;
    end
  end

  sequence s_take;
    req && !busy;
  endsequence
  sequence s_rsv_take;
    s_take ##0 addr >= {3'h0, RSV_BASE};
  endsequence

  AST_ANSWER_NEXT: assert property (s_take |=> cmd_done)
    else $error("request taken without answer");
  AST_NO_STRAY_ANSWER: assert property (cmd_done |-> $past(req) && !$past(busy))
    else $error("answer without request");
  AST_REFUSE_QUIET: assert property (refused |-> cmd_done && !err_reset && !busy)
    else $error("refusal with side effect");
  AST_REFUSE_ZERO: assert property (refused |-> rdata == 8'h00)
    else $error("refused request returned data");
  AST_DEBUG_NO_RESET: assert property (s_take ##0 kind inside {rq_dbg_rd, rq_dbg_wr,
    rq_dbg_page_erase, rq_dbg_dev_erase} |=> !err_reset)
    else $error("debug request caused reset");
  AST_RSV_USER_RESET: assert property (s_rsv_take ##0 kind == rq_code_rd
    |=> err_reset && cmd_done)
    else $error("reserved user read not reset");
  AST_RSV_DEBUG_REFUSE: assert property (s_rsv_take ##0 kind inside {rq_dbg_rd, rq_dbg_wr,
    rq_dbg_page_erase} |=> refused && !busy)
    else $error("reserved debug access not refused");
  AST_BUSY_ONLY_FLASH: assert property ($rose(busy) |-> cmd_done && $past(req) &&
    $past(kind) inside {rq_xmove_wr, rq_dbg_wr, rq_dbg_page_erase, rq_dbg_dev_erase})
    else $error("busy without flash request");
  AST_PLAIN_NO_BUSY: assert property (s_take ##0 kind inside {rq_sfr_wr, rq_sfr_rd,
    rq_code_rd, rq_dbg_rd} |=> !busy)
    else $error("plain request started operation");
  AST_OP_END: assert property (op_done |-> $fell(busy))
    else $error("op done not at busy end");
  AST_OP_LENGTH: assert property ($fell(busy) |-> op_done && busy_len_r inside
    {[WRITE_CYC - 1:WRITE_CYC + 1], [ERASE_CYC - 1:ERASE_CYC + 1]})
    else $error("operation length wrong");
  AST_ERR_PULSE: assert property (err_reset |-> cmd_done ##1 !err_reset)
    else $error("error reset not one pulse");
endmodule : flash_guard_properties

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import flash_guard_pkg::*;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic [1:0] r;} exp_s;
  localparam logic [15:0] LOCK_A = {3'h0, LOCK_ADDR};
  localparam logic [15:0] RSV_A = {3'h0, RSV_BASE};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, dev_reset, ferr_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [31:0] seed = 32'hB473C3D1;
  logic [15:0] fa;
  logic [7:0] rd;
  int n_fail = 0, cmp_count = 0, n_rst = 0;
  exp_s rq[$];
  logic [1:0] bq[$];
  flash_guard_if lnk();

  always #2 aclk = ~aclk;

  flash_guard_host i_flash_guard_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(lnk), .irq);
  flash_guard_device i_flash_guard_device (.aclk, .aresetn, .link(lnk), .dev_reset,
    .ferr_flag);
  flash_guard_properties i_flash_guard_properties (.aclk, .aresetn, .req(lnk.req),
    .kind(lnk.kind), .addr(lnk.addr), .wdata(lnk.wdata), .busy(lnk.busy),
    .cmd_done(lnk.cmd_done), .rdata(lnk.rdata), .refused(lnk.refused),
    .op_done(lnk.op_done), .err_reset(lnk.err_reset));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // Results are judged here so drivers never compare inline
  always @(posedge aclk) begin
    exp_s e;
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, e.r});
      if (e.m != 32'h0) check("rdata", s_axi_rdata & e.m, e.v & e.m);
    end
    if (s_axi_bvalid && s_axi_bready) check("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
  end

  always @(posedge aclk) begin
    if (dev_reset === 1'b1) n_rst <= n_rst + 1;
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  // Mask zero marks a poll whose data is not judged
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
    input logic [1:0] r, output logic [31:0] d);
    rq.push_back('{v, m, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
    input logic [1:0] r = RESP_OKAY);
    logic [31:0] d;
    axi_rd(a, v, m, r, d);
  endtask : chk_rd

  // Waits for both the answer and the end of any flash operation
  task automatic cmd(input req_kind_e k, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] s;
    axi_wr(ADDR_OFF, {16'h0, a}, RESP_OKAY);
    axi_wr(WDATA_OFF, {24'h0, d}, RESP_OKAY);
    axi_wr(CTRL_OFF, {29'h0, k}, RESP_OKAY);
    s = 32'h0000_0100;
    while (s[STATUS_BUSY_BIT] !== 1'b0 || lnk.busy !== 1'b0) begin
      axi_rd(STATUS_OFF, 32'h0, 32'h0, RESP_OKAY, s);
    end
  endtask : cmd

  task automatic rd_op(input req_kind_e k, input logic [15:0] a, input logic [7:0] v);
    cmd(k, a, 8'h00);
    chk_rd(STATUS_OFF, {24'h0, v}, 32'hFF);
  endtask : rd_op

  task automatic key(input logic [1:0] c);
    rd_op(rq_sfr_rd, {8'h00, KEY_LOCK_ADDR}, {6'h00, c});
  endtask : key

  task automatic store_ctrl(input logic [7:0] v);
    cmd(rq_sfr_wr, {8'h00, STORE_CTRL_ADDR}, v);
  endtask : store_ctrl

  task automatic unlock;
    cmd(rq_sfr_wr, {8'h00, KEY_LOCK_ADDR}, KEY_FIRST);
    cmd(rq_sfr_wr, {8'h00, KEY_LOCK_ADDR}, KEY_SECOND);
  endtask : unlock

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    key(KEY_CODE_LOCKED);
    rd_op(rq_sfr_rd, {8'h00, STORE_CTRL_ADDR}, STORE_CTRL_RESET);
    axi_wr(8'h40, 32'h0, RESP_SLVERR);
    chk_rd(INT_CLR_OFF, 32'h0, 32'h0, RESP_SLVERR);
    cmd(rq_sfr_wr, {8'h00, KEY_LOCK_ADDR}, KEY_FIRST);
    key(KEY_CODE_FIRST);
    cmd(rq_sfr_wr, {8'h00, KEY_LOCK_ADDR}, KEY_SECOND);
    key(KEY_CODE_UNLOCKED);
    store_ctrl(8'h01);
    rd_op(rq_sfr_rd, {8'h00, STORE_CTRL_ADDR}, 8'h01);
    seed = xs(seed);
    fa = {8'h01, seed[7:0]};
    rd = seed[15:8];
    cmd(rq_xmove_wr, fa, rd);
    key(KEY_CODE_LOCKED);
    rd_op(rq_code_rd, fa, rd);
    unlock();
    store_ctrl(8'h03);
    cmd(rq_xmove_wr, 16'h0000, seed[23:16]);
    rd_op(rq_code_rd, fa, ERASED);
    key(KEY_CODE_LOCKED);
    store_ctrl(8'h01);
    cmd(rq_xmove_wr, fa, 8'h00);
    key(KEY_CODE_DISABLED);
    unlock();
    key(KEY_CODE_DISABLED);
    rd_op(rq_code_rd, fa, ERASED);
    check("irq", {31'h0, irq}, 32'h0);
    axi_wr(INT_EN_OFF, 32'h1 << INT_REFUSED, RESP_OKAY);
    axi_wr(INT_CLR_OFF, 32'hF, RESP_OKAY);
    rd_op(rq_dbg_rd, RSV_A, 8'h00);
    check("irq", {31'h0, irq}, 32'h1);
    chk_rd(INT_STAT_OFF, 32'h3, 32'hF);
    check("resets", n_rst, 0);
    axi_wr(INT_CLR_OFF, 32'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq", {31'h0, irq}, 32'h0);
    cmd(rq_code_rd, RSV_A, 8'h00);
    check("resets", n_rst, 1);
    check("ferr", {31'h0, ferr_flag}, 32'h1);
    chk_rd(INT_STAT_OFF, (32'h1 << INT_CMD_DONE) | (32'h1 << INT_FERR), 32'hF);
    cmd(rq_sfr_rd, {8'h00, RST_CAUSE_ADDR}, 8'h00);
    chk_rd(STATUS_OFF, 32'h1 << FLASH_ERR_BIT, 32'h1 << FLASH_ERR_BIT);
    key(KEY_CODE_LOCKED);
    unlock();
    store_ctrl(8'h01);
    cmd(rq_xmove_wr, LOCK_A, 8'hFE);
    rd_op(rq_dbg_rd, fa, ERASED);
    cmd(rq_code_rd, RSV_A, 8'h00);
    rd_op(rq_dbg_rd, fa, 8'h00);
    rd_op(rq_dbg_rd, LOCK_A, 8'h00);
    rd_op(rq_code_rd, LOCK_A, 8'hFE);
    unlock();
    store_ctrl(8'h01);
    cmd(rq_xmove_wr, LOCK_A, 8'hFC);
    check("resets", n_rst, 3);
    cmd(rq_dbg_wr, LOCK_A, 8'hFC);
    check("resets", n_rst, 3);
    unlock();
    store_ctrl(8'h03);
    cmd(rq_xmove_wr, LOCK_A, 8'h00);
    check("resets", n_rst, 4);
    cmd(rq_dbg_dev_erase, 16'h0000, 8'h00);
    rd_op(rq_code_rd, LOCK_A, ERASED);
    rd_op(rq_dbg_rd, fa, ERASED);
    chk_rd(INT_STAT_OFF, 32'h1 << INT_OP_DONE, 32'h1 << INT_OP_DONE);
    cmd(rq_sfr_wr, {8'h00, KEY_LOCK_ADDR}, 8'h5A);
    key(KEY_CODE_DISABLED);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_sim();
  end
endmodule : tb_top
